// ===== odt_pkg.sv
// Purpose: Constants and state types for the oscillator divider and trim control
// Assumes: 16-bit registers reached over a plain strobe port
// Notes:   Addresses are word slots on a 3-bit address

package odt_pkg;

  localparam logic [2:0]  ADDR_OSC_LO  = 3'h0;
  localparam logic [2:0]  ADDR_OSC_HI  = 3'h1;
  localparam logic [2:0]  ADDR_CLOCK_DIVIDER  = 3'h2;
  localparam logic [2:0]  ADDR_TRIM    = 3'h3;

  localparam logic [7:0]  KEY_HI_1     = 8'h78;
  localparam logic [7:0]  KEY_HI_2     = 8'h9a;
  localparam logic [7:0]  KEY_LO_1     = 8'h46;
  localparam logic [7:0]  KEY_LO_2     = 8'h57;

  // Oscillator control bit positions
  localparam int          OC_SEL_LOCK  = 7;
  localparam int          OC_PIN_LOCK  = 6;
  localparam int          OC_CF        = 3;
  localparam int          OC_POSC      = 2;
  localparam int          OC_SOSC      = 1;
  localparam int          OC_OSW       = 0;

  // Clock divider bit positions
  localparam int          CD_ROI       = 15;
  localparam int          CD_DOZE_LSB  = 12;
  localparam int          CD_SLOWDOWN_ENABLE     = 11;
  localparam int          CD_FAST_RC_POSTSCALER_LSB = 8;
  localparam int          CD_PLL_BRANCH_POSTSCALER_LSB = 6;
  localparam int          CD_PLL_ALWAYS_ON     = 5;

  // Trim bit positions
  localparam int          TR_SELF_TRIM_ENABLE      = 15;
  localparam int          TR_IDLE      = 13;
  localparam int          TR_SRC       = 12;
  localparam int          TR_LPOL      = 10;
  localparam int          TR_RPOL      = 8;

  localparam logic [2:0]  DOZE_RST     = 3'h3;
  localparam logic [2:0]  FAST_RC_POSTSCALER_RST    = 3'h1;
  localparam logic [2:0]  OSC_PRI_PLL  = 3'h3;
  localparam logic [2:0]  OSC_FRC_PLL  = 3'h1;

  // Settle time after the new source is ready
  localparam logic [3:0]  SETTLE_CYC   = 4'ha;

  // Reference windows for frequency measurement
  localparam logic [4:0]  REF_N_USB    = 5'h01;
  localparam logic [4:0]  REF_N_SOSC   = 5'h1f;
  localparam logic [13:0] EXP_USB      = 14'h1f40;
  localparam logic [13:0] EXP_SOSC     = 14'h1e84;
  localparam logic [14:0] TOL_LOCK     = 15'h0010;
  localparam logic [14:0] TOL_RANGE    = 15'h0078;

  typedef enum logic [4:0] {
    UNL_IDLE = 5'b00001,
    UNL_HI1  = 5'b00010,
    UNL_HIOK = 5'b00100,
    UNL_LO1  = 5'b01000,
    UNL_LOOK = 5'b10000
  } odt_unl_t;

  typedef enum logic [2:0] {
    SW_IDLE   = 3'b001,
    SW_WAIT   = 3'b010,
    SW_SETTLE = 3'b100
  } odt_sw_t;

  typedef struct packed {
    odt_unl_t    unl;
    odt_sw_t     sw;
    logic [3:0]  settle;
    logic        init_done;
    logic [2:0]  current_oscillator_field;
    logic [2:0]  new_oscillator_field;
    logic        sel_lock;
    logic        pin_lock;
    logic        pll_locked;
    logic        cf;
    logic        posc_en;
    logic        sosc_en;
    logic        osw;
    logic        recover_on_interrupt;
    logic [2:0]  doze;
    logic        slowdown_enable;
    logic [2:0]  fast_rc_postscaler;
    logic [1:0]  pll_branch_postscaler;
    logic        pll_always_on;
    logic        self_trim_enable;
    logic        stidle;
    logic        trim_reference_select;
    logic        trim_locked_status;
    logic        trim_lock_irq_polarity;
    logic        trim_out_of_range;
    logic        range_irq_polarity;
    logic [5:0]  trim;
    logic [4:0]  refcnt;
    logic [13:0] frccnt;
    logic        irq;
    logic [15:0] rdata;
  } odt_state_t;

  localparam odt_state_t STATE_RST = '{
    unl: UNL_IDLE, sw: SW_IDLE, doze: DOZE_RST, fast_rc_postscaler: FAST_RC_POSTSCALER_RST, default: '0
  };

endpackage : odt_pkg

// ===== odt_ctrl.sv
// Purpose: Oscillator control, clock divider and fast RC self-trim registers
// Assumes: All inputs synchronous to clk_sys_i; tick inputs are one-cycle pulses
// Notes:   Notes on behaviour below
//
// Notes on behaviour
// - Monitor on and lock set refuses selections
// - Pin lock bit shows configuration lock
// - PLL status reads lock only while running
// - Switch start or non-PLL mode clears status; with PLL always-on set, non-PLL mode keeps it following lock
// - Failure sets flag; a software write of 0 or a switch start clears it
// - Primary sleep enable keeps oscillator in Sleep
// - Secondary enable bit drives 32 kHz oscillator
// - Request starts switch, reads 0 when done
// - Interrupt clears slowdown when recover set
// - Ratio code gives 1:2^code, reset 011
// - Slowdown off forces ratio 1:1
// - PLL branch postscaler code divides 1..8
// - PLL runs always or in PLL modes
// - Self-trim on makes trim field read-only
// - Idle-halt bit stops trimming in Idle
// - Reference select: USB frames or 32 kHz
// - Locked status within 0.2 percent
// - Out-of-range status suspends trimming
// - Polarity bits choose interrupt condition
// - Trim is signed offset from center
// - Completion clears request, copies selection
// - Key pairs unlock each control byte
// - Self-trim raises interrupt on drift
//
// Chosen here: the address-and-strobe port and the register addresses.

`timescale 1ns/10ps
`default_nettype none

module odt_ctrl
  import odt_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic [2:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic [2:0]  init_osc_i,
  input  wire logic        fail_safe_clock_monitor_i,
  input  wire logic        one_way_pin_lock_config_i,
  input  wire logic        clock_fail_i,
  input  wire logic        osc_ready_i,
  input  wire logic        pll_lock_i,
  input  wire logic        irq_event_i,
  input  wire logic        idle_i,
  input  wire logic        frc_tick_i,
  input  wire logic        sof_tick_i,
  input  wire logic        sosc_tick_i,
  output logic      [2:0]  current_oscillator_o,
  output logic             switch_busy_o,
  output logic             pin_config_lock_o,
  output logic             primary_sleep_enable_o,
  output logic             secondary_osc_enable_o,
  output logic             pll_enable_o,
  output logic      [2:0]  doze_ratio_o,
  output logic      [2:0]  fast_rc_postscaler_o,
  output logic      [1:0]  pll_branch_postscaler_o,
  output logic      [5:0]  trim_field_o,
  output logic             self_trim_interrupt_o
);

  odt_state_t s_r;
  odt_state_t s_nxt;

  logic        sel_locked;
  logic        wr_lo_ok;
  logic        wr_hi_ok;
  logic        current_oscillator_field_pll;
  logic        new_oscillator_field_pll;
  logic        pll_run;
  logic        trim_run;
  logic        ref_tick;
  logic [4:0]  ref_n;
  logic [13:0] exp_cnt;
  logic [14:0] err;
  logic [14:0] err_abs;
  logic [7:0]  wb;

  assign wb        = wdata_i[7:0];
  assign sel_locked = fail_safe_clock_monitor_i & s_r.sel_lock;
  assign wr_lo_ok  = wr_i && addr_i == ADDR_OSC_LO && s_r.unl == UNL_LOOK;
  assign wr_hi_ok  = wr_i && addr_i == ADDR_OSC_HI && s_r.unl == UNL_HIOK;
  assign current_oscillator_field_pll  = s_r.current_oscillator_field == OSC_PRI_PLL || s_r.current_oscillator_field == OSC_FRC_PLL;
  assign new_oscillator_field_pll  = s_r.new_oscillator_field == OSC_PRI_PLL || s_r.new_oscillator_field == OSC_FRC_PLL;
  assign pll_run   = s_r.pll_always_on | current_oscillator_field_pll | (s_r.sw != SW_IDLE && new_oscillator_field_pll);
  assign trim_run  = s_r.self_trim_enable & ~(s_r.stidle & idle_i);
  assign ref_tick  = s_r.trim_reference_select ? sof_tick_i : (sosc_tick_i & s_r.sosc_en);
  assign ref_n     = s_r.trim_reference_select ? REF_N_USB : REF_N_SOSC;
  assign exp_cnt   = s_r.trim_reference_select ? EXP_USB : EXP_SOSC;
  assign err       = {1'b0, s_r.frccnt} - {1'b0, exp_cnt};
  assign err_abs   = err[14] ? 15'(-err) : err;

  always_comb begin
    s_nxt = s_r;

    // Strap load of the oscillator selection after reset release
    if (!s_r.init_done) begin
      s_nxt.init_done = 1'b1;
      s_nxt.current_oscillator_field      = init_osc_i;
      s_nxt.new_oscillator_field      = init_osc_i;
    end

    if (wr_i) begin
      unique case (s_r.unl)
        UNL_IDLE: begin
          if (addr_i == ADDR_OSC_HI && wb == KEY_HI_1) begin
            s_nxt.unl = UNL_HI1;
          end else if (addr_i == ADDR_OSC_LO && wb == KEY_LO_1) begin
            s_nxt.unl = UNL_LO1;
          end
        end
        UNL_HI1: begin
          s_nxt.unl = (addr_i == ADDR_OSC_HI && wb == KEY_HI_2) ? UNL_HIOK : UNL_IDLE;
        end
        UNL_LO1: begin
          s_nxt.unl = (addr_i == ADDR_OSC_LO && wb == KEY_LO_2) ? UNL_LOOK : UNL_IDLE;
        end
        UNL_HIOK, UNL_LOOK: begin
          s_nxt.unl = UNL_IDLE;
        end
      endcase
    end

    if (wr_hi_ok && !sel_locked && s_r.sw == SW_IDLE) begin
      s_nxt.new_oscillator_field = wb[2:0];
    end

    if (wr_lo_ok) begin
      if (wb[OC_SEL_LOCK]) begin
        s_nxt.sel_lock = 1'b1;
      end
      if (!(one_way_pin_lock_config_i && s_r.pin_lock)) begin
        s_nxt.pin_lock = wb[OC_PIN_LOCK];
      end
      if (!wb[OC_CF]) begin
        s_nxt.cf = 1'b0;
      end
      s_nxt.posc_en = wb[OC_POSC];
      s_nxt.sosc_en = wb[OC_SOSC];
      if (wb[OC_OSW] && !sel_locked) begin
        s_nxt.osw = 1'b1;
      end
    end

    // PLL lock status follows the running PLL
    s_nxt.pll_locked = pll_lock_i & pll_run;

    unique case (s_r.sw)
      SW_IDLE: begin
        if (s_r.osw) begin
          if (s_r.new_oscillator_field == s_r.current_oscillator_field) begin
            s_nxt.osw = 1'b0;
          end else begin
            s_nxt.pll_locked = 1'b0;
            s_nxt.cf         = 1'b0;
            s_nxt.sw         = SW_WAIT;
          end
        end
      end
      SW_WAIT: begin
        if (osc_ready_i && (!new_oscillator_field_pll || pll_lock_i)) begin
          s_nxt.settle = '0;
          s_nxt.sw     = SW_SETTLE;
        end
      end
      SW_SETTLE: begin
        s_nxt.settle = s_r.settle + 4'h1;
        if (s_r.settle == SETTLE_CYC - 4'h1) begin
          s_nxt.current_oscillator_field = s_r.new_oscillator_field;
          s_nxt.osw  = 1'b0;
          s_nxt.sw   = SW_IDLE;
        end
      end
    endcase

    if (clock_fail_i) begin
      s_nxt.cf = 1'b1;
    end

    if (wr_i && addr_i == ADDR_CLOCK_DIVIDER) begin
      s_nxt.recover_on_interrupt   = wdata_i[CD_ROI];
      s_nxt.doze  = wdata_i[CD_DOZE_LSB +: 3];
      s_nxt.slowdown_enable = wdata_i[CD_SLOWDOWN_ENABLE];
      s_nxt.fast_rc_postscaler = wdata_i[CD_FAST_RC_POSTSCALER_LSB +: 3];
      s_nxt.pll_branch_postscaler = wdata_i[CD_PLL_BRANCH_POSTSCALER_LSB +: 2];
      s_nxt.pll_always_on = wdata_i[CD_PLL_ALWAYS_ON];
    end
    if (irq_event_i && s_r.recover_on_interrupt) begin
      s_nxt.slowdown_enable = 1'b0;
    end

    if (wr_i && addr_i == ADDR_TRIM) begin
      s_nxt.self_trim_enable    = wdata_i[TR_SELF_TRIM_ENABLE];
      s_nxt.stidle  = wdata_i[TR_IDLE];
      s_nxt.trim_reference_select   = wdata_i[TR_SRC];
      s_nxt.trim_lock_irq_polarity  = wdata_i[TR_LPOL];
      s_nxt.range_irq_polarity = wdata_i[TR_RPOL];
      if (!s_r.self_trim_enable) begin
        s_nxt.trim = wdata_i[5:0];
      end
    end

    // Frequency measurement over the reference window
    if (!trim_run) begin
      s_nxt.refcnt = '0;
      s_nxt.frccnt = '0;
    end else begin
      if (frc_tick_i && s_r.frccnt != 14'h3fff) begin
        s_nxt.frccnt = s_r.frccnt + 14'h1;
      end
      if (ref_tick) begin
        s_nxt.refcnt = s_r.refcnt + 5'h1;
        if (s_r.refcnt == ref_n - 5'h1) begin
          s_nxt.refcnt = '0;
          s_nxt.frccnt = '0;
          s_nxt.trim_locked_status = err_abs <= TOL_LOCK;
          s_nxt.trim_out_of_range   = err_abs > TOL_RANGE;
          if (err_abs > TOL_LOCK && err_abs <= TOL_RANGE) begin
            if (err[14] && s_r.trim != 6'h1f) begin
              s_nxt.trim = s_r.trim + 6'h1;
            end else if (!err[14] && s_r.trim != 6'h20) begin
              s_nxt.trim = s_r.trim - 6'h1;
            end
          end
        end
      end
    end

    s_nxt.irq = s_r.self_trim_enable & ((s_r.trim_locked_status ^ s_r.trim_lock_irq_polarity) | (s_r.trim_out_of_range ^ s_r.range_irq_polarity));

    s_nxt.rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        ADDR_OSC_LO, ADDR_OSC_HI: begin
          s_nxt.rdata = {1'b0, s_r.current_oscillator_field, 1'b0, s_r.new_oscillator_field, s_r.sel_lock, s_r.pin_lock,
                         s_r.pll_locked, 1'b0, s_r.cf, s_r.posc_en, s_r.sosc_en, s_r.osw};
        end
        ADDR_CLOCK_DIVIDER: begin
          s_nxt.rdata = {s_r.recover_on_interrupt, s_r.doze, s_r.slowdown_enable, s_r.fast_rc_postscaler, s_r.pll_branch_postscaler, s_r.pll_always_on, 5'h00};
        end
        ADDR_TRIM: begin
          s_nxt.rdata = {s_r.self_trim_enable, 1'b0, s_r.stidle, s_r.trim_reference_select, s_r.trim_locked_status, s_r.trim_lock_irq_polarity,
                         s_r.trim_out_of_range, s_r.range_irq_polarity, 2'b00, s_r.trim};
        end
        default: begin
          s_nxt.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_o                 = s_r.rdata;
  assign current_oscillator_o    = s_r.current_oscillator_field;
  assign switch_busy_o           = s_r.osw;
  assign pin_config_lock_o       = s_r.pin_lock;
  assign primary_sleep_enable_o  = s_r.posc_en;
  assign secondary_osc_enable_o  = s_r.sosc_en;
  assign pll_enable_o            = pll_run;
  assign doze_ratio_o            = s_r.slowdown_enable ? s_r.doze : 3'h0;
  assign fast_rc_postscaler_o    = s_r.fast_rc_postscaler;
  assign pll_branch_postscaler_o = s_r.pll_branch_postscaler;
  assign trim_field_o            = s_r.trim;
  assign self_trim_interrupt_o   = s_r.irq;

  property p_fail_sets;
    @(posedge clk_sys_i) disable iff (rst_i) clock_fail_i |=> s_r.cf;
  endproperty
  a_fail_sets: assert property (p_fail_sets) else $error("fail flag not set");

  property p_switch_clears_lock;
    @(posedge clk_sys_i) disable iff (rst_i)
      (s_r.sw == SW_IDLE && s_r.osw && s_r.new_oscillator_field != s_r.current_oscillator_field) |=> (!s_r.pll_locked && s_r.sw == SW_WAIT);
  endproperty
  a_switch_clears_lock: assert property (p_switch_clears_lock) else $error("lock not cleared");

  property p_switch_done;
    @(posedge clk_sys_i) disable iff (rst_i)
      (s_r.sw == SW_WAIT && s_nxt.sw == SW_SETTLE) |-> ##11 (!s_r.osw && s_r.current_oscillator_field == s_r.new_oscillator_field);
  endproperty
  a_switch_done: assert property (p_switch_done) else $error("switch did not complete");

  property p_no_doze;
    @(posedge clk_sys_i) disable iff (rst_i) !s_r.slowdown_enable |-> doze_ratio_o == 3'h0;
  endproperty
  a_no_doze: assert property (p_no_doze) else $error("ratio not 1:1");

  property p_roi;
    @(posedge clk_sys_i) disable iff (rst_i) (irq_event_i && s_r.recover_on_interrupt) |=> !s_r.slowdown_enable;
  endproperty
  a_roi: assert property (p_roi) else $error("slowdown not cleared");

  property p_trim_ro;
    @(posedge clk_sys_i) disable iff (rst_i)
      (wr_i && addr_i == ADDR_TRIM && s_r.self_trim_enable && !ref_tick) |=> $stable(s_r.trim);
  endproperty
  a_trim_ro: assert property (p_trim_ro) else $error("trim written while self-trim");

  property p_idle_halt;
    @(posedge clk_sys_i) disable iff (rst_i)
      (s_r.stidle && idle_i) |=> (s_r.frccnt == 14'h0000 && s_r.refcnt == 5'h00);
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("trimming ran in Idle");

  property p_pll_off;
    @(posedge clk_sys_i) disable iff (rst_i)
      (!s_r.pll_always_on && !current_oscillator_field_pll && s_r.sw == SW_IDLE) |-> !pll_enable_o ##1 !s_r.pll_locked;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("PLL active outside PLL mode");

  property p_hi_key;
    @(posedge clk_sys_i) disable iff (rst_i)
      (wr_i && addr_i == ADDR_OSC_HI && s_r.unl != UNL_HIOK && s_r.init_done) |=> $stable(s_r.new_oscillator_field);
  endproperty
  a_hi_key: assert property (p_hi_key) else $error("high byte written without keys");

  property p_locked;
    @(posedge clk_sys_i) disable iff (rst_i)
      (sel_locked && wr_lo_ok && !s_r.osw) |=> !s_r.osw;
  endproperty
  a_locked: assert property (p_locked) else $error("switch accepted while locked");

endmodule : odt_ctrl

`default_nettype wire

// ===== odt_ctrl_bench.sv
// Purpose: Self-checking bench for the oscillator divider and trim control block
// Assumes: Registers reached through the plain strobe port, read data one cycle later
// Notes:   Selection lock is set-only, so its scenario runs last

`timescale 1ns/10ps
`default_nettype none

module odt_ctrl_bench;
  import odt_pkg::*;

  logic        clk_sys_i;
  logic        rst_i;
  logic [2:0]  addr_i;
  logic [15:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [15:0] rdata_o;
  logic        fsm_on;
  logic        clock_fail_i;
  logic        osc_ready_i;
  logic        pll_lock_i;
  logic        irq_event_i;
  logic        idle_i;
  logic        frc_tick_i;
  logic        sof_tick_i;
  logic [2:0]  cur_osc;
  logic        busy;
  logic        pin_lock;
  logic        posc_en;
  logic        sosc_en;
  logic        pll_en;
  logic [2:0]  doze;
  logic [2:0]  frc_div;
  logic [1:0]  pll_div;
  logic [5:0]  trim;
  logic        trim_irq;
  logic [15:0] v;
  logic [5:0]  t0;
  int          fail_count;
  int          tests_run;
  int          cyc;
  int          sof_period;
  int          sof_cnt;

  odt_ctrl dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .init_osc_i(3'h7), .fail_safe_clock_monitor_i(fsm_on),
    .one_way_pin_lock_config_i(1'b1), .clock_fail_i(clock_fail_i), .osc_ready_i(osc_ready_i),
    .pll_lock_i(pll_lock_i), .irq_event_i(irq_event_i), .idle_i(idle_i), .frc_tick_i(frc_tick_i),
    .sof_tick_i(sof_tick_i), .sosc_tick_i(1'b0), .current_oscillator_o(cur_osc), .switch_busy_o(busy),
    .pin_config_lock_o(pin_lock), .primary_sleep_enable_o(posc_en), .secondary_osc_enable_o(sosc_en),
    .pll_enable_o(pll_en), .doze_ratio_o(doze), .fast_rc_postscaler_o(frc_div),
    .pll_branch_postscaler_o(pll_div), .trim_field_o(trim), .self_trim_interrupt_o(trim_irq)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // All bus tasks start just after a rising edge; wr leaves the strobe up for chaining
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
  endtask : wr

  task automatic gap;
    wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : gap

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge clk_sys_i);
  endtask : rd

  task automatic rchk(input string name, input logic [2:0] a, input logic [15:0] mask, input logic [15:0] exp);
    rd(a, v);
    chk(name, exp, v & mask);
  endtask : rchk

  // key pair just before each byte write
  task automatic key_hi(input logic [7:0] d);
    wr(ADDR_OSC_HI, {8'h00, KEY_HI_1});
    wr(ADDR_OSC_HI, {8'h00, KEY_HI_2});
    wr(ADDR_OSC_HI, {8'h00, d});
    gap();
  endtask : key_hi

  task automatic key_lo(input logic [7:0] d);
    wr(ADDR_OSC_LO, {8'h00, KEY_LO_1});
    wr(ADDR_OSC_LO, {8'h00, KEY_LO_2});
    wr(ADDR_OSC_LO, {8'h00, d});
    gap();
  endtask : key_lo

  task automatic wait_switch;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk("switch_done", 16'h0000, {15'h0, busy});
  endtask : wait_switch

  // Reference frames: one start-of-frame pulse every sof_period cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      fail_count++;
      close_out();
    end
    if (sof_period == 0 || sof_cnt >= sof_period - 1) begin
      sof_cnt    <= 0;
      sof_tick_i <= (sof_period != 0);
    end else begin
      sof_cnt    <= sof_cnt + 1;
      sof_tick_i <= 1'b0;
    end
  end

  initial begin
    fail_count = 0;
    tests_run = 0;
    cyc = 0;
    sof_period = 0;
    sof_cnt = 0;
    rst_i = 1'b1;
    addr_i = 3'h0;
    wdata_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    fsm_on = 1'b0;
    clock_fail_i = 1'b0;
    osc_ready_i = 1'b0;
    pll_lock_i = 1'b0;
    irq_event_i = 1'b0;
    idle_i = 1'b0;
    frc_tick_i = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    frc_tick_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rchk("osc_rst", ADDR_OSC_LO, 16'hffff, 16'h7700);
    rchk("div_rst", ADDR_CLOCK_DIVIDER, 16'hffff, 16'h3100);
    rchk("trim_rst", ADDR_TRIM, 16'hffff, 16'h0000);
    chk("frc_div_rst", 16'h0001, {13'h0, frc_div});
    chk("doze_rst", 16'h0000, {13'h0, doze});
    wr(ADDR_OSC_HI, 16'h0000);
    gap();
    rchk("hi_nokey", ADDR_OSC_HI, 16'hffff, 16'h7700);
    key_hi(8'h00);
    rchk("hi_key", ADDR_OSC_HI, 16'hffff, 16'h7000);
    key_lo(8'h01);
    repeat (20) @(posedge clk_sys_i);
    chk("switch_wait", 16'h0001, {15'h0, busy});
    osc_ready_i <= 1'b1;
    wait_switch();
    rchk("frc_done", ADDR_OSC_LO, 16'hffff, 16'h0000);
    chk("cur_frc", 16'h0000, {13'h0, cur_osc});
    chk("pll_off", 16'h0000, {15'h0, pll_en});
    key_hi(8'h03);
    key_lo(8'h01);
    repeat (3) @(posedge clk_sys_i);
    rchk("pll_switching", ADDR_OSC_LO, 16'hffff, 16'h0301);
    pll_lock_i <= 1'b1;
    wait_switch();
    repeat (2) @(posedge clk_sys_i);
    rchk("pll_locked", ADDR_OSC_LO, 16'hffff, 16'h3320);
    chk("pll_on", 16'h0001, {15'h0, pll_en});
    key_lo(8'h46);
    rchk("low_bits", ADDR_OSC_LO, 16'hffff, 16'h3366);
    chk("pins", 16'h0007, {13'h0, pin_lock, posc_en, sosc_en});
    key_lo(8'h00);
    rchk("one_way", ADDR_OSC_LO, 16'hffff, 16'h3360);
    chk("pins_off", 16'h0004, {13'h0, pin_lock, posc_en, sosc_en});
    clock_fail_i <= 1'b1;
    @(posedge clk_sys_i);
    clock_fail_i <= 1'b0;
    @(posedge clk_sys_i);
    rchk("cf_set", ADDR_OSC_LO, 16'hffff, 16'h3368);
    key_lo(8'h40);
    rchk("cf_clr", ADDR_OSC_LO, 16'hffff, 16'h3360);
    // no USB here, so branch codes 10 and 11 are allowed
    wr(ADDR_CLOCK_DIVIDER, 16'hffe0);
    gap();
    rchk("div_all", ADDR_CLOCK_DIVIDER, 16'hffff, 16'hffe0);
    chk("div_outs", 16'h01ff, {5'h0, doze, frc_div, pll_div, 1'b1});
    irq_event_i <= 1'b1;
    @(posedge clk_sys_i);
    irq_event_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rchk("roi_clr", ADDR_CLOCK_DIVIDER, 16'hffff, 16'hf7e0);
    chk("doze_1to1", 16'h0000, {13'h0, doze});
    wr(ADDR_CLOCK_DIVIDER, 16'h2800);
    gap();
    irq_event_i <= 1'b1;
    @(posedge clk_sys_i);
    irq_event_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rchk("roi_off", ADDR_CLOCK_DIVIDER, 16'hffff, 16'h2800);
    chk("doze_2", 16'h0002, {13'h0, doze});
    wr(ADDR_TRIM, 16'h0005);
    gap();
    rchk("trim_sw", ADDR_TRIM, 16'hffff, 16'h0005);
    wr(ADDR_TRIM, 16'h9005);
    wr(ADDR_TRIM, 16'h9010);
    gap();
    chk("trim_ro", 16'h0005, {10'h0, trim});
    sof_period <= 7950;
    repeat (3 * 7950 + 100) @(posedge clk_sys_i);
    chk("trim_up", 16'h0001, {15'h0, (trim > 6'h05) && (trim < 6'h0a)});
    rchk("trim_mid", ADDR_TRIM, 16'hff00, 16'h9000);
    chk("irq_mid", 16'h0000, {15'h0, trim_irq});
    sof_period <= 8000;
    repeat (2 * 8000 + 100) @(posedge clk_sys_i);
    rchk("trim_lock", ADDR_TRIM, 16'hff00, 16'h9800);
    chk("irq_lock", 16'h0001, {15'h0, trim_irq});
    wr(ADDR_TRIM, 16'h9400);
    gap();
    repeat (3) @(posedge clk_sys_i);
    chk("irq_pol", 16'h0000, {15'h0, trim_irq});
    sof_period <= 7000;
    repeat (2 * 7000 + 100) @(posedge clk_sys_i);
    rchk("trim_range", ADDR_TRIM, 16'hff00, 16'h9600);
    chk("irq_range", 16'h0001, {15'h0, trim_irq});
    t0 = trim;
    repeat (7100) @(posedge clk_sys_i);
    chk("trim_frozen", {10'h0, t0}, {10'h0, trim});
    wr(ADDR_TRIM, 16'hb400);
    gap();
    idle_i <= 1'b1;
    sof_period <= 8000;
    repeat (2 * 8000 + 100) @(posedge clk_sys_i);
    rchk("trim_idle", ADDR_TRIM, 16'hff00, 16'hb600);
    idle_i <= 1'b0;
    sof_period <= 0;
    key_lo(8'hc0);
    key_hi(8'h00);
    rchk("lock_no_mon", ADDR_OSC_LO, 16'hffff, 16'h30e0);
    fsm_on <= 1'b1;
    @(posedge clk_sys_i);
    key_hi(8'h03);
    rchk("lock_hi", ADDR_OSC_LO, 16'hffff, 16'h30e0);
    key_lo(8'hc1);
    chk("lock_req", 16'h0000, {15'h0, busy});
    close_out();
  end

endmodule : odt_ctrl_bench

`default_nettype wire
